// ### brx_core_model.sv
// brx_core_model.sv: stack frame the core left at interrupt entry.
// assumes the bench pushes it flags first, then pc high, then pc low.
`timescale 1ns/1ps
`default_nettype none
module brx_core_model #(
	parameter logic [7:0] SAVED_FLAGS = 8'hC0,
	parameter logic [15:0] SAVED_PC = 16'h2345
) (
	output logic [23:0] frame
);
	assign frame = {SAVED_FLAGS, SAVED_PC};
endmodule : brx_core_model
`default_nettype wire

// ### brx_exec.sv
// brx_exec.sv: execution of interrupt return, absolute jump and relative jump,
// driven by software over apb; assumes one clock pclk and async reset presetn.
// Functional notes
// - normal return pops flags at sp, sp plus one, then pc, sp plus two
// - every interrupt return sets bit zero of system mode register
// - stack-based return only when fast interrupt status bit (flags bit one) is zero
// - fast return copies shadow flags, clears fast status bit, no stack access
// - return is one-byte opcode BF; 10 or 12 cycles normal, 6 fast
// - fast entry and fast return swap program counter and instruction pointer; here fast return loads iptr with pc plus one, not pc
// - conditional absolute jump, 3 bytes, 8 cycles, loads direct target if true
// - unconditional jump opcode 30, 2 bytes, 8 cycles, pc from register pair
// - conditional relative jump, 2 bytes, 6 cycles, adds offset if true
// - signed 8-bit offset added to address after the instruction
// - jumps never modify any flag bit
// - condition code is the 4-bit high nibble, opcode the low nibble
// - system mode bit zero is the global interrupt enable
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "brx_regs.svh"
module brx_exec #(
	parameter int STK_AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic global_irq_enable,
	output logic busy
);
	typedef struct packed {
		brx_pkg::brx_state_t st;
		brx_pkg::brx_kind_t kind;
		logic [4:0] cyc;
		logic [7:0] opc;
		logic [15:0] opa;
		logic [7:0] flags;
		logic [7:0] shadow;
		logic [7:0] smode;
		logic [15:0] pc;
		logic [15:0] iptr;
		logic [15:0] sp;
		logic [15:0] pair;
		logic alt_stk;
		logic taken;
		logic bad_op;
		logic done;
		logic [7:0] pcl;
		logic [31:0] rdata;
	} brx_state_s_t;

	brx_state_s_t cur_ff;
	brx_state_s_t nxt_st;
	logic [7:0] stk_rdata;
	logic stk_we;
	logic [STK_AW-1:0] stk_waddr;
	logic [STK_AW-1:0] stk_raddr;
	logic [7:0] stk_wdata;
	logic wr_acc;
	logic rd_setup;

	// condition evaluation from carry, zero, sign, overflow
	function automatic logic brx_cond(input logic [3:0] cc, input logic [7:0] f);
		logic c;
		logic z;
		logic s;
		logic v;
		logic r;
		c = f[`BRX_FLG_C];
		z = f[`BRX_FLG_Z];
		s = f[`BRX_FLG_S];
		v = f[`BRX_FLG_V];
		case (cc)
			4'h0: r = 1'b0;
			4'h1: r = s ^ v;
			4'h2: r = z | (s ^ v);
			4'h3: r = c | z;
			4'h4: r = v;
			4'h5: r = s;
			4'h6: r = z;
			4'h7: r = c;
			4'h8: r = 1'b1;
			4'h9: r = ~(s ^ v);
			4'hA: r = ~(z | (s ^ v));
			4'hB: r = ~(c | z);
			4'hC: r = ~v;
			4'hD: r = ~s;
			4'hE: r = ~z;
			4'hF: r = ~c;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : brx_cond

	// stack addresses wrap inside the small on-chip stack
	function automatic logic [STK_AW-1:0] brx_sa(input logic [15:0] a);
		return a[STK_AW-1:0];
	endfunction : brx_sa

	// sign-extends the relative offset to the program counter width
	function automatic logic [15:0] brx_sext(input logic [7:0] ofs);
		return {{8{ofs[7]}}, ofs};
	endfunction : brx_sext

	assign wr_acc = psel & penable & pwrite;
	// read data is captured in the setup phase, so prdata already stands
	// when the zero-wait access edge samples it
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign prdata = cur_ff.rdata;
	assign global_irq_enable = cur_ff.smode[`BRX_MODE_GIE];
	assign busy = (cur_ff.st != brx_pkg::BRX_IDLE);
	// software loads stack bytes through the stack data register at sp
	assign stk_we = wr_acc && (paddr == `BRX_OFF_STKDAT) && !busy;
	assign stk_waddr = brx_sa(cur_ff.sp);
	assign stk_wdata = pwdata[7:0];

	always_comb begin
		nxt_st = cur_ff;
		stk_raddr = brx_sa(cur_ff.sp);
		pslverr = 1'b0;
		if (psel && penable) begin
			case (paddr)
				`BRX_OFF_CTRL, `BRX_OFF_OPC, `BRX_OFF_OPA, `BRX_OFF_FLAGS, `BRX_OFF_SHADOW,
				`BRX_OFF_SYSMODE, `BRX_OFF_PC, `BRX_OFF_IPTR, `BRX_OFF_SP, `BRX_OFF_PAIR,
				`BRX_OFF_STATUS, `BRX_OFF_STKDAT: pslverr = 1'b0;
				default: pslverr = 1'b1;
			endcase
		end
		if (rd_setup) begin
			case (paddr)
				`BRX_OFF_OPC: nxt_st.rdata = {24'h000000, cur_ff.opc};
				`BRX_OFF_OPA: nxt_st.rdata = {16'h0000, cur_ff.opa};
				`BRX_OFF_FLAGS: nxt_st.rdata = {24'h000000, cur_ff.flags};
				`BRX_OFF_SHADOW: nxt_st.rdata = {24'h000000, cur_ff.shadow};
				`BRX_OFF_SYSMODE: nxt_st.rdata = {24'h000000, cur_ff.smode};
				`BRX_OFF_PC: nxt_st.rdata = {16'h0000, cur_ff.pc};
				`BRX_OFF_IPTR: nxt_st.rdata = {16'h0000, cur_ff.iptr};
				`BRX_OFF_SP: nxt_st.rdata = {16'h0000, cur_ff.sp};
				`BRX_OFF_PAIR: nxt_st.rdata = {16'h0000, cur_ff.pair};
				`BRX_OFF_STATUS: nxt_st.rdata = {26'h0000000, cur_ff.bad_op, cur_ff.taken,
					cur_ff.done, busy, cur_ff.alt_stk, 1'b0};
				default: nxt_st.rdata = 32'h00000000;
			endcase
		end
		// writes are refused while an instruction runs so its operands cannot tear
		if (wr_acc && !busy) begin
			case (paddr)
				`BRX_OFF_OPC: nxt_st.opc = pwdata[7:0];
				`BRX_OFF_OPA: nxt_st.opa = pwdata[15:0];
				`BRX_OFF_FLAGS: nxt_st.flags = pwdata[7:0];
				`BRX_OFF_SHADOW: nxt_st.shadow = pwdata[7:0];
				`BRX_OFF_SYSMODE: nxt_st.smode = pwdata[7:0];
				`BRX_OFF_PC: nxt_st.pc = pwdata[15:0];
				`BRX_OFF_IPTR: nxt_st.iptr = pwdata[15:0];
				`BRX_OFF_SP: nxt_st.sp = pwdata[15:0];
				`BRX_OFF_PAIR: nxt_st.pair = pwdata[15:0];
				`BRX_OFF_STKDAT: nxt_st.sp = cur_ff.sp + 16'h0001;
				`BRX_OFF_CTRL: begin
					nxt_st.alt_stk = pwdata[`BRX_CTRL_ALTSTK];
					if (pwdata[`BRX_CTRL_FENTRY]) begin
						nxt_st.kind = brx_pkg::BRX_K_FENTRY;
						nxt_st.st = brx_pkg::BRX_WAIT;
						nxt_st.cyc = `BRX_CYC_FENTRY - 5'd1;
						nxt_st.done = 1'b0;
					end else if (pwdata[`BRX_CTRL_GO]) begin
						nxt_st.done = 1'b0;
						nxt_st.taken = 1'b0;
						nxt_st.bad_op = 1'b0;
						nxt_st.st = brx_pkg::BRX_WAIT;
						// the kind is fixed here; later writes are refused until done
						if (cur_ff.opc == `BRX_OPC_INTRET) begin
							if (cur_ff.flags[`BRX_FLG_FSTAT]) begin
								nxt_st.kind = brx_pkg::BRX_K_RET_F;
								nxt_st.cyc = `BRX_CYC_RET_FAST - 5'd1;
							end else begin
								nxt_st.kind = brx_pkg::BRX_K_RET_N;
								nxt_st.st = brx_pkg::BRX_POP_FLAGS;
								nxt_st.cyc = (pwdata[`BRX_CTRL_ALTSTK] ? `BRX_CYC_RET_ALT
									: `BRX_CYC_RET_NORM) - 5'd1;
							end
						end else if (cur_ff.opc == `BRX_OPC_JPIND) begin
							nxt_st.kind = brx_pkg::BRX_K_JPIND;
							nxt_st.cyc = `BRX_CYC_ABSJ - 5'd1;
						end else if (cur_ff.opc[3:0] == `BRX_NIB_JPCC) begin
							nxt_st.kind = brx_pkg::BRX_K_ABS;
							nxt_st.cyc = `BRX_CYC_ABSJ - 5'd1;
						end else if (cur_ff.opc[3:0] == `BRX_NIB_JRCC) begin
							nxt_st.kind = brx_pkg::BRX_K_REL;
							nxt_st.cyc = `BRX_CYC_RELJ - 5'd1;
						end else begin
							nxt_st.kind = brx_pkg::BRX_K_BAD;
							nxt_st.cyc = 5'd0;
						end
					end
				end
				default: nxt_st.rdata = cur_ff.rdata;
			endcase
		end
		// the counter runs down in every state while busy
		if (busy && cur_ff.cyc != 5'd0) begin
			nxt_st.cyc = cur_ff.cyc - 5'd1;
		end
		// the pops run in the first cycles and the counter pads the rest, so
		// the whole instruction takes its fixed number of cycles
		case (cur_ff.st)
			brx_pkg::BRX_IDLE: nxt_st.st = nxt_st.st;
			brx_pkg::BRX_POP_FLAGS: begin
				// read address already presented at sp; data arrives next cycle
				stk_raddr = brx_sa(cur_ff.sp);
				nxt_st.sp = cur_ff.sp + 16'h0001;
				nxt_st.st = brx_pkg::BRX_POP_PCL;
			end
			brx_pkg::BRX_POP_PCL: begin
				nxt_st.flags = stk_rdata;
				stk_raddr = brx_sa(cur_ff.sp);
				nxt_st.st = brx_pkg::BRX_POP_PCH;
			end
			brx_pkg::BRX_POP_PCH: begin
				// high byte first, then low byte, as the core pushed them
				nxt_st.pcl = stk_rdata;
				stk_raddr = brx_sa(cur_ff.sp + 16'h0001);
				nxt_st.st = brx_pkg::BRX_FINISH;
			end
			brx_pkg::BRX_FINISH: begin
				nxt_st.pc = {nxt_st.pcl, stk_rdata};
				nxt_st.sp = cur_ff.sp + 16'h0002;
				nxt_st.st = brx_pkg::BRX_WAIT;
			end
			brx_pkg::BRX_WAIT: begin
				if (cur_ff.cyc == 5'd0) begin
					nxt_st.st = brx_pkg::BRX_IDLE;
					nxt_st.done = 1'b1;
					case (cur_ff.kind)
						brx_pkg::BRX_K_RET_N: begin
							nxt_st.smode[`BRX_MODE_GIE] = 1'b1;
						end
						brx_pkg::BRX_K_RET_F: begin
							nxt_st.flags = cur_ff.shadow;
							nxt_st.flags[`BRX_FLG_FSTAT] = 1'b0;
							nxt_st.pc = cur_ff.iptr;
							// one past the single-byte return, ready for the next entry
							nxt_st.iptr = cur_ff.pc + 16'h0001;
							nxt_st.smode[`BRX_MODE_GIE] = 1'b1;
						end
						brx_pkg::BRX_K_FENTRY: begin
							nxt_st.pc = cur_ff.iptr;
							nxt_st.iptr = cur_ff.pc;
							// the interrupted flags wait in the shadow copy
							nxt_st.shadow = cur_ff.flags;
							nxt_st.flags[`BRX_FLG_FSTAT] = 1'b1;
						end
						brx_pkg::BRX_K_ABS: begin
							nxt_st.taken = brx_cond(cur_ff.opc[7:4], cur_ff.flags);
							nxt_st.pc = brx_cond(cur_ff.opc[7:4], cur_ff.flags)
								? cur_ff.opa : cur_ff.pc + 16'h0003;
						end
						brx_pkg::BRX_K_JPIND: begin
							nxt_st.taken = 1'b1;
							nxt_st.pc = cur_ff.pair;
						end
						brx_pkg::BRX_K_REL: begin
							nxt_st.taken = brx_cond(cur_ff.opc[7:4], cur_ff.flags);
							// offset counts from the byte after the 2-byte jump
							nxt_st.pc = cur_ff.pc + 16'h0002 + (brx_cond(cur_ff.opc[7:4],
								cur_ff.flags) ? brx_sext(cur_ff.opa[7:0])
								: 16'h0000);
						end
						default: nxt_st.bad_op = 1'b1;
					endcase
				end
			end
			default: nxt_st.st = brx_pkg::BRX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_ff <= '{
				st: brx_pkg::BRX_IDLE,
				kind: brx_pkg::BRX_K_NONE,
				sp: `BRX_RST_SP,
				pc: `BRX_RST_PC,
				default: '0
			};
		end else begin
			cur_ff <= nxt_st;
		end
	end

	brx_stack_mem #(
		.AW(STK_AW)
	) u_stack (
		.pclk(pclk),
		.we(stk_we),
		.waddr(stk_waddr),
		.wdata(stk_wdata),
		.raddr(stk_raddr),
		.rdata(stk_rdata)
	);
endmodule : brx_exec
`default_nettype wire

// ### brx_exec_sva.sv
// brx_exec_sva.sv: port-level checks of the branch and interrupt-return block.
// assumes the apb map of brx_regs.svh and one clock pclk.
`timescale 1ns/1ps
`default_nettype none
`include "brx_regs.svh"
module brx_exec_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic global_irq_enable,
	input wire logic busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic go_wr;
	logic sym_wr;
	assign acc = psel && penable && pready;
	assign go_wr = acc && pwrite && paddr == `BRX_OFF_CTRL && pwdata[0] && !busy;
	assign sym_wr = acc && pwrite && paddr == `BRX_OFF_SYSMODE && !busy;
	sequence run_min;
		busy [*6];
	endsequence
	sequence run_end;
		##[6:12] !busy;
	endsequence
	busy_start_a: assert property (go_wr |=> busy)
		else $error("busy missing after go");
	run_min_a: assert property ($rose(busy) |-> run_min)
		else $error("instruction shorter than six cycles");
	run_max_a: assert property ($rose(busy) |-> run_end)
		else $error("instruction longer than twelve cycles");
	gie_write_a: assert property (sym_wr |=> global_irq_enable == $past(pwdata[0]))
		else $error("enable does not follow mode write");
	gie_cause_a: assert property ($changed(global_irq_enable) |-> $past(busy) || $past(sym_wr))
		else $error("enable changed without cause");
	gie_fall_a: assert property ($fell(global_irq_enable) |-> $past(sym_wr))
		else $error("enable cleared by execution");
	gie_read_a: assert property (acc && !pwrite && paddr == `BRX_OFF_SYSMODE
		|-> prdata[0] == $past(global_irq_enable)) else $error("mode readback wrong");
	busy_read_a: assert property (acc && !pwrite && paddr == `BRX_OFF_STATUS
		|-> prdata[2] == $past(busy)) else $error("status busy wrong");
endmodule : brx_exec_sva
bind brx_exec brx_exec_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable), .busy(busy));
`default_nettype wire

// ### brx_pkg.sv
// brx_pkg.sv: types shared by the branch and interrupt-return execution block.
// assumes brx_regs.svh supplies the numeric constants.
`default_nettype none
package brx_pkg;

	typedef enum logic [2:0] {
		BRX_IDLE,
		BRX_POP_FLAGS,
		BRX_POP_PCL,
		BRX_POP_PCH,
		BRX_WAIT,
		BRX_FINISH
	} brx_state_t;

	typedef enum logic [2:0] {
		BRX_K_NONE,
		BRX_K_RET_N,
		BRX_K_RET_F,
		BRX_K_ABS,
		BRX_K_JPIND,
		BRX_K_REL,
		BRX_K_FENTRY,
		BRX_K_BAD
	} brx_kind_t;

endpackage : brx_pkg
`default_nettype wire

// ### brx_regs.svh
// brx_regs.svh: register offsets, field positions, reset values and cycle counts
// for the branch and interrupt-return execution block; definitions only.
`ifndef BRX_REGS_SVH
`define BRX_REGS_SVH

// register byte addresses on the apb slave
`define BRX_OFF_CTRL 12'h000
`define BRX_OFF_OPC 12'h004
`define BRX_OFF_OPA 12'h008
`define BRX_OFF_FLAGS 12'h00C
`define BRX_OFF_SHADOW 12'h010
`define BRX_OFF_SYSMODE 12'h014
`define BRX_OFF_PC 12'h018
`define BRX_OFF_IPTR 12'h01C
`define BRX_OFF_SP 12'h020
`define BRX_OFF_PAIR 12'h024
`define BRX_OFF_STATUS 12'h028
`define BRX_OFF_STKDAT 12'h02C

// flag bit positions, flags register address and system mode enable bit
`define BRX_FLG_C 7
`define BRX_FLG_Z 6
`define BRX_FLG_S 5
`define BRX_FLG_V 4
`define BRX_FLG_FSTAT 1
`define BRX_FLAGS_ADDR 8'hD5
`define BRX_MODE_GIE 0

// control register fields
`define BRX_CTRL_GO 0
`define BRX_CTRL_FENTRY 1
`define BRX_CTRL_ALTSTK 2

// opcodes
`define BRX_OPC_INTRET 8'hBF
`define BRX_OPC_JPIND 8'h30
`define BRX_NIB_JPCC 4'hD
`define BRX_NIB_JRCC 4'hB

// instruction cycle counts
`define BRX_CYC_RET_NORM 5'd10
`define BRX_CYC_RET_ALT 5'd12
`define BRX_CYC_RET_FAST 5'd6
`define BRX_CYC_ABSJ 5'd8
`define BRX_CYC_RELJ 5'd6
`define BRX_CYC_FENTRY 5'd6

// reset values
`define BRX_RST_SP 16'h0100
`define BRX_RST_PC 16'h0000

`endif

// ### brx_stack_mem.sv
// brx_stack_mem.sv: small byte-wide stack memory with registered read data.
// assumes one clock, writes and reads addressed by the low address bits.
`timescale 1ns/1ps
`default_nettype none
module brx_stack_mem #(
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : brx_stack_mem
`default_nettype wire

// ### tb.sv
// tb.sv: self-checking bench for brx_exec over apb.
// assumes zero-wait slave with prdata standing in the access phase.
`timescale 1ns/1ps
`default_nettype none
`include "brx_regs.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gie, busy, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] frame;
	int mismatches = 0;
	int num_checks = 0;
	brx_core_model core (.frame(frame));
	brx_exec #(.STK_AW(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.global_irq_enable(gie), .busy(busy));
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// let the access edge settle before callers look at outputs
		@(negedge pclk);
	endtask : apb
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask : rchk
	// starts the loaded instruction and counts the falling edges at which busy stands
	task automatic run(input logic [31:0] c, input int n);
		int k;
		k = 0;
		apb(1'b1, `BRX_OFF_CTRL, c);
		while (busy === 1'b1 && k < 40) begin
			k++;
			@(negedge pclk);
		end
		chk("cycles", k, n);
	endtask : run
	task automatic jump(input logic [7:0] op, input logic [7:0] f, input logic [15:0] opa,
		input logic [15:0] pc0, input int n, input logic [15:0] epc);
		apb(1'b1, `BRX_OFF_FLAGS, {24'h0, f});
		apb(1'b1, `BRX_OFF_OPC, {24'h0, op});
		apb(1'b1, `BRX_OFF_OPA, {16'h0, opa});
		apb(1'b1, `BRX_OFF_PC, {16'h0, pc0});
		run(32'h1, n);
		rchk("pc", `BRX_OFF_PC, {16'h0, epc});
		rchk("flags", `BRX_OFF_FLAGS, {24'h0, f});
	endtask : jump
	task automatic t_jumps;
		for (int c = 0; c < 16; c++) begin
			jump({c[3:0], `BRX_NIB_JRCC}, 8'h00, 16'h0080, 16'h1000, 6,
				c >= 8 ? 16'h0F82 : 16'h1002);
			jump({c[3:0], `BRX_NIB_JPCC}, 8'hF0, 16'hBEEF, 16'h2000, 8,
				(c >= 2 && c <= 9) ? 16'hBEEF : 16'h2003);
		end
		jump({4'h8, `BRX_NIB_JRCC}, 8'h80, 16'h007F, 16'h1000, 6, 16'h1081);
		apb(1'b1, `BRX_OFF_PAIR, 32'h0120);
		jump(`BRX_OPC_JPIND, 8'h40, 16'h0000, 16'h3000, 8, 16'h0120);
	endtask : t_jumps
	task automatic t_intret(input logic [31:0] c, input int n);
		apb(1'b1, `BRX_OFF_SP, 32'h80);
		for (int i = 2; i >= 0; i--) apb(1'b1, `BRX_OFF_STKDAT, {24'h0, frame[i*8 +: 8]});
		apb(1'b1, `BRX_OFF_SP, 32'h80);
		apb(1'b1, `BRX_OFF_SYSMODE, 32'h0);
		chk("gie off", gie, 1'b0);
		apb(1'b1, `BRX_OFF_FLAGS, 32'h0);
		apb(1'b1, `BRX_OFF_OPC, {24'h0, `BRX_OPC_INTRET});
		run(c, n);
		chk("gie on", gie, 1'b1);
		if (c == 32'h1) begin
			rchk("flags", `BRX_OFF_FLAGS, {24'h0, frame[23:16]});
			rchk("pc", `BRX_OFF_PC, {16'h0, frame[15:0]});
			rchk("sp", `BRX_OFF_SP, 32'h83);
		end
	endtask : t_intret
	task automatic t_fast;
		apb(1'b1, `BRX_OFF_SYSMODE, 32'h0);
		apb(1'b1, `BRX_OFF_SP, 32'h90);
		apb(1'b1, `BRX_OFF_FLAGS, 32'h02);
		apb(1'b1, `BRX_OFF_SHADOW, 32'h52);
		apb(1'b1, `BRX_OFF_PC, 32'h00FF);
		apb(1'b1, `BRX_OFF_IPTR, 32'h0345);
		apb(1'b1, `BRX_OFF_OPC, {24'h0, `BRX_OPC_INTRET});
		run(32'h1, 6);
		chk("gie fast", gie, 1'b1);
		rchk("flags", `BRX_OFF_FLAGS, 32'h50);
		rchk("sp", `BRX_OFF_SP, 32'h90);
		rchk("pc", `BRX_OFF_PC, 32'h0345);
		rchk("iptr", `BRX_OFF_IPTR, 32'h0100);
		run(32'h2, `BRX_CYC_FENTRY);
		rchk("entry pc", `BRX_OFF_PC, 32'h0100);
		rchk("entry iptr", `BRX_OFF_IPTR, 32'h0345);
		rchk("entry shadow", `BRX_OFF_SHADOW, 32'h50);
		rchk("entry flags", `BRX_OFF_FLAGS, 32'h52);
		rchk("status", `BRX_OFF_STATUS, 32'h08);
	endtask : t_fast
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rchk("mode rst", `BRX_OFF_SYSMODE, 32'h0);
		chk("slverr mapped", err, 1'b0);
		rchk("unmapped", 12'h030, 32'h0);
		chk("slverr unmapped", err, 1'b1);
		t_jumps();
		t_intret(32'h1, 10);
		t_intret(32'h5, 12);
		t_fast();
		tally_and_finish();
	end
	initial begin
		#(40 * 20000);
		mismatches++;
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
